// ### rtl/ascfg_pkg.sv
// Purpose: Shared types and constants for the address-space configuration select
// Assumes: Mode codes follow a 5-bit processor mode field
// Notes:   Mode code values are fixed localparams of this package, not overridable
package ascfg_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned NARROW_AW = 26;
  localparam int unsigned WIDE_AW   = 32;
  localparam int unsigned MODE_W    = 5;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] USER_NARROW_MODE       = 5'h00;
  localparam logic [MODE_W-1:0] FAST_IRQ_NARROW_MODE   = 5'h01;
  localparam logic [MODE_W-1:0] IRQ_NARROW_MODE        = 5'h02;
  localparam logic [MODE_W-1:0] SUPERVISOR_NARROW_MODE = 5'h03;
  localparam logic [MODE_W-1:0] NARROW_FAMILY_MASK     = 5'h10;
  localparam logic [MODE_W-1:0] RESET_MODE             = SUPERVISOR_NARROW_MODE;

  // ----------------------------------------------------------------
  // Configuration selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASCFG_NARROW_ALL,
    ASCFG_NARROW_PROG_WIDE_DATA,
    ASCFG_WIDE_ALL,
    ASCFG_UNDEFINED
  } ascfg_sel_t;

  typedef struct packed {
    logic program_space_wide_bit;
    logic data_space_wide_bit;
  } ascfg_ctrl_t;

  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic              valid;
  } ascfg_mode_req_t;

  typedef struct packed {
    logic addr_exc_en;
    logic narrow_prog;
    logic wide_data;
  } ascfg_gate_t;

endpackage

// ### rtl/ascfg_decode.sv
// Purpose: Decode the two control bits into an address-space configuration
// Assumes: Control bits are synchronous to ref_clk
// Notes:   Purely combinational; the top registers the result
`timescale 1ns/1ns
module ascfg_decode (
  input  wire ascfg_pkg::ascfg_ctrl_t ctrl,   // Control bits
  output      ascfg_pkg::ascfg_sel_t  sel,    // Decoded configuration
  output      ascfg_pkg::ascfg_gate_t gate    // Derived gating terms
);

  always_comb begin
    // RULE7: decode every cycle
    case ({ctrl.program_space_wide_bit, ctrl.data_space_wide_bit})
      2'b00:   sel = ascfg_pkg::ASCFG_NARROW_ALL;
      2'b01:   sel = ascfg_pkg::ASCFG_NARROW_PROG_WIDE_DATA;
      2'b11:   sel = ascfg_pkg::ASCFG_WIDE_ALL;
      default: sel = ascfg_pkg::ASCFG_UNDEFINED;
    endcase
    gate.narrow_prog = ~ctrl.program_space_wide_bit;
    gate.wide_data   = ctrl.data_space_wide_bit;
    // RULE1: narrow data checks
    // RULE3: wide data disables checks
    gate.addr_exc_en = ~ctrl.data_space_wide_bit;
  end

endmodule

// ### rtl/ascfg_select.sv
// Function
// RULE1: Both bits low gives 26-bit program and data space, legacy behaviour.
// RULE2: All-narrow refuses 32-bit modes; exceptions enter the matching 26-bit mode.
// RULE3: Narrow program, wide data: as all-narrow but address exceptions disabled.
// RULE4: Both bits high gives 32-bit space, legacy narrow programs still run.
// RULE5: Software must not set program wide with data narrow.
// RULE6: With narrow program space, only the four narrow modes are usable. Only mode requests are limited; exception entry and the drop just clear bit 4.
// RULE7: Decode bits every cycle; gate address exceptions and mode changes.
//
// Purpose: Address-space configuration select and processor mode guard
// Assumes: Mode requests and exceptions arrive as one-cycle valid pulses
// Notes:   Undefined configuration is treated as wide program, narrow data
`timescale 1ns/1ns
module ascfg_select (
  input  wire                         ref_clk,       // Processor clock
  input  wire                         rst,           // Async reset, active high
  input  wire ascfg_pkg::ascfg_ctrl_t ctrl,          // Control register bits
  input  wire ascfg_pkg::ascfg_mode_req_t mode_req,  // Software mode change
  input  wire ascfg_pkg::ascfg_mode_req_t exc_req,   // Exception entry, target mode; family from config
  input  wire [ascfg_pkg::WIDE_AW-1:0] data_addr,    // Data transfer address
  input  wire                         data_valid,    // Data transfer strobe
  output logic [1:0]                  cfg_sel,       // Registered configuration
  output logic [ascfg_pkg::MODE_W-1:0] cur_mode,     // Current processor mode
  output logic                        mode_refused,  // Mode request refused pulse
  output logic                        addr_exc,      // Address exception pulse
  output logic                        addr_exc_en    // Address checks enabled
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  ascfg_pkg::ascfg_sel_t  sel;
  ascfg_pkg::ascfg_gate_t gate;

  ascfg_decode u_dec (
    .ctrl (ctrl),
    .sel  (sel),
    .gate (gate)
  );

  // ----------------------------------------------------------------
  // Mode and check state
  // ----------------------------------------------------------------
  logic [1:0]                   sel_q,     sel_d;
  logic [ascfg_pkg::MODE_W-1:0] mode_q,    mode_d;
  logic                         refuse_q,  refuse_d;
  logic                         aexc_q,    aexc_d;
  logic                         aen_q,     aen_d;
  logic                         req_narrow;
  logic [ascfg_pkg::MODE_W-1:0] exc_narrow;
  logic                         hi_bits;

  always_comb begin
    sel_d    = sel;
    mode_d   = mode_q;
    refuse_d = 1'b0;
    aen_d    = gate.addr_exc_en;
    // RULE6: narrow modes only
    req_narrow = ((mode_req.mode & ascfg_pkg::NARROW_FAMILY_MASK) == '0) &&
                 (mode_req.mode <= ascfg_pkg::SUPERVISOR_NARROW_MODE);
    // Exception target folded into the narrow family
    exc_narrow = exc_req.mode & ~ascfg_pkg::NARROW_FAMILY_MASK;
    hi_bits = |data_addr[ascfg_pkg::WIDE_AW-1:ascfg_pkg::NARROW_AW];
    // RULE1: out of 26-bit range trap
    // RULE3: checks gated by data bit
    aexc_d = data_valid && gate.addr_exc_en && hi_bits;
    if (exc_req.valid) begin
      // RULE2: narrow exception entry
      if (gate.narrow_prog) begin
        mode_d = exc_narrow;
      end else begin
        // RULE4: wide family entry
        mode_d = exc_req.mode | ascfg_pkg::NARROW_FAMILY_MASK;
      end
    end else if (aexc_d) begin
      // Address exception enters the narrow supervisor mode, whatever the active family
      mode_d = ascfg_pkg::SUPERVISOR_NARROW_MODE;
    end else if (mode_req.valid) begin
      // RULE2: refuse wide modes
      // RULE7: mode legality gate
      if (gate.narrow_prog && !req_narrow) begin
        refuse_d = 1'b1;
      end else begin
        // RULE4: legacy modes allowed too
        mode_d = mode_req.mode;
      end
    end else if (gate.narrow_prog &&
                 ((mode_q & ascfg_pkg::NARROW_FAMILY_MASK) != '0)) begin
      // RULE6: drop to narrow twin
      // Idle request fields must not keep a wide mode alive
      mode_d = mode_q & ~ascfg_pkg::NARROW_FAMILY_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_q    <= 2'h0;
      mode_q   <= ascfg_pkg::RESET_MODE;
      refuse_q <= 1'b0;
      aexc_q   <= 1'b0;
      aen_q    <= 1'b1;
    end else begin
      sel_q    <= sel_d;
      mode_q   <= mode_d;
      refuse_q <= refuse_d;
      aexc_q   <= aexc_d;
      aen_q    <= aen_d;
    end
  end

  assign cfg_sel      = sel_q;
  assign cur_mode     = mode_q;
  assign mode_refused = refuse_q;
  assign addr_exc     = aexc_q;
  assign addr_exc_en  = aen_q;

endmodule

// ### tb/ascfg_select_checker.sv
// Purpose: Port assertions for the configuration select
// Assumes: One clock domain, async reset
// Notes:   Bound from the bench top
`timescale 1ns/1ns
module ascfg_select_checker (
  input wire                             ref_clk,      // Clock
  input wire                             rst,          // Reset
  input wire ascfg_pkg::ascfg_ctrl_t     ctrl,         // Bits
  input wire ascfg_pkg::ascfg_mode_req_t mode_req,     // Mode ask
  input wire ascfg_pkg::ascfg_mode_req_t exc_req,      // Exception
  input wire [31:0]                      data_addr,    // Address
  input wire                             data_valid,   // Strobe
  input wire [1:0]                       cfg_sel,      // Config
  input wire [4:0]                       cur_mode,     // Mode
  input wire                             mode_refused, // Refused
  input wire                             addr_exc,     // Fault
  input wire                             addr_exc_en   // Checks on
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire quiet = !exc_req.valid && !data_valid;
  sequence bad_req;
    mode_req.valid && mode_req.mode[4] && quiet && !ctrl[1] && cfg_sel < 2'h2;
  endsequence
  // Two samples, so a mode drop may land one edge late
  sequence narrow_held;
    (cfg_sel < 2'h2) [*2];
  endsequence
  all_narrow_a: assert property (ctrl == 2'h0 |=> cfg_sel == 2'h0 && addr_exc_en)
    else $error("all narrow decode wrong");
  wide_refused_a: assert property (bad_req |=> mode_refused && $stable(cur_mode))
    else $error("wide mode not refused");
  exc_narrow_a: assert property (exc_req.valid && ctrl == 2'h0 && cfg_sel == 2'h0
    |=> cur_mode == ($past(exc_req.mode) & 5'h0f)) else $error("exception mode wrong");
  addr_check_a: assert property (data_valid && !exc_req.valid
    |=> addr_exc == $past(!ctrl[0] && data_addr[31:26] != 6'h0)) else $error("addr check");
  wide_exc_a: assert property (exc_req.valid && ctrl == 2'h3 && cfg_sel == 2'h2
    |=> cur_mode == $past(exc_req.mode)) else $error("wide exception mode wrong");
  narrow_modes_a: assert property (narrow_held |-> cur_mode <= 5'h03)
    else $error("wide mode with narrow program");
  mode_accept_a: assert property (mode_req.valid && quiet && ctrl == 2'h3 && cfg_sel == 2'h2
    |=> !mode_refused && cur_mode == $past(mode_req.mode)) else $error("mode not taken");
endmodule

// ### tb/tb.sv
// Purpose: Directed bench for the configuration select
// Assumes: Inputs change on the falling edge
// Notes:   Each request is a one-cycle pulse
`timescale 1ns/1ns
module tb;
  logic                       ref_clk = 1'h0;
  logic                       rst = 1'h1;
  ascfg_pkg::ascfg_ctrl_t     ctrl = '0;
  ascfg_pkg::ascfg_mode_req_t mode_req = '0;
  ascfg_pkg::ascfg_mode_req_t exc_req = '0;
  logic [31:0]                data_addr = '0;
  logic                       data_valid = 1'h0;
  logic [1:0]                 cfg_sel;
  logic [4:0]                 cur_mode;
  logic                       mode_refused, addr_exc, addr_exc_en;
  int                         errors = 0, compares = 0, cycles = 0;
  ascfg_select ascfg_select_i (.ref_clk(ref_clk), .rst(rst), .ctrl(ctrl), .mode_req(mode_req),
    .exc_req(exc_req), .data_addr(data_addr), .data_valid(data_valid), .cfg_sel(cfg_sel),
    .cur_mode(cur_mode), .mode_refused(mode_refused), .addr_exc(addr_exc),
    .addr_exc_en(addr_exc_en));
  always #10 ref_clk = ~ref_clk;
  task automatic results;
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input string n, input logic [4:0] e, input logic [4:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Kind 0 mode change, 1 exception, 2 data transfer
  task automatic go(input logic [1:0] k, input logic [4:0] m, input logic [31:0] a);
    mode_req = '{mode: m, valid: k == 2'h0};
    exc_req = '{mode: m, valid: k == 2'h1};
    data_addr = a;
    data_valid = k == 2'h2;
    @(negedge ref_clk);
    mode_req.valid = 1'h0;
    exc_req.valid = 1'h0;
    data_valid = 1'h0;
  endtask
  task automatic setc(input logic [1:0] c);
    ctrl = c;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic t_narrow;
    setc(2'h0);
    chk("cfg_sel", 5'h00, cfg_sel);
    go(2'h0, 5'h13, 32'h0);
    chk("mode_refused", 5'h01, mode_refused);
    chk("cur_mode", 5'h03, cur_mode);
    for (int i = 0; i < 4; i++) begin
      go(2'h0, i[4:0], 32'h0);
      chk("cur_mode", i[4:0], cur_mode);
    end
    go(2'h1, 5'h12, 32'h0);
    chk("cur_mode", 5'h02, cur_mode);
    go(2'h2, 5'h00, 32'h03ff_ffff);
    chk("addr_exc", 5'h00, addr_exc);
    go(2'h2, 5'h00, 32'h0400_0000);
    chk("addr_exc", 5'h01, addr_exc);
    chk("cur_mode", 5'h03, cur_mode);
  endtask
  task automatic t_split;
    setc(2'h1);
    chk("addr_exc_en", 5'h00, addr_exc_en);
    go(2'h2, 5'h00, 32'hffff_fffc);
    chk("addr_exc", 5'h00, addr_exc);
    go(2'h0, 5'h10, 32'h0);
    chk("mode_refused", 5'h01, mode_refused);
  endtask
  task automatic t_wide;
    setc(2'h3);
    chk("cfg_sel", 5'h02, cfg_sel);
    go(2'h1, 5'h12, 32'h0);
    chk("cur_mode", 5'h12, cur_mode);
    go(2'h0, 5'h00, 32'h0);
    chk("cur_mode", 5'h00, cur_mode);
    go(2'h0, 5'h11, 32'h0);
    setc(2'h0);
    chk("cur_mode", 5'h01, cur_mode);
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    chk("cur_mode", 5'h03, cur_mode);
    rst = 1'h0;
    t_narrow();
    t_split();
    t_wide();
    results();
  end
endmodule
bind ascfg_select ascfg_select_checker ascfg_select_checker_i (.ref_clk(ref_clk), .rst(rst),
  .ctrl(ctrl), .mode_req(mode_req), .exc_req(exc_req), .data_addr(data_addr),
  .data_valid(data_valid), .cfg_sel(cfg_sel), .cur_mode(cur_mode),
  .mode_refused(mode_refused), .addr_exc(addr_exc), .addr_exc_en(addr_exc_en));
